// ===== rtl/pfpb_regs.svh
// Constants for the fetch, predict and bypass pipeline core
`ifndef PFPB_REGS_SVH
`define PFPB_REGS_SVH
`define PFPB_RESET_PC    32'h0000_0000
`define PFPB_PC_STEP     32'h0000_0004
`define PFPB_OP_UBR      8'hf0
`define PFPB_OP_CBR      8'he0
`define PFPB_I_OP        31:24
`define PFPB_I_RX        23:20
`define PFPB_I_RY        19:16
`define PFPB_I_PRED      15
`define PFPB_I_DISP      14:0
`define PFPB_I_DISP_MSB  14
`define PFPB_CW_ALU      2:0
`define PFPB_CW_SHM      4:3
`define PFPB_CW_SHA      9:5
`define PFPB_CW_WR       10
`define PFPB_CW_IMM      11
`define PFPB_CW_CND      13:12
`define PFPB_ALU_ADD     3'h0
`define PFPB_ALU_SUB     3'h1
`define PFPB_ALU_AND     3'h2
`define PFPB_ALU_OR      3'h3
`define PFPB_ALU_XOR     3'h4
`define PFPB_SH_LEFT     2'h1
`define PFPB_SH_RIGHT    2'h2
`define PFPB_SH_ROT      2'h3
`define PFPB_CND_EQ      2'h0
`define PFPB_CND_NE      2'h1
`define PFPB_CND_LT      2'h2
`define PFPB_IC_AW       6
`define PFPB_IC_IDX      7:2
`define PFPB_IC_TAG      31:8
`define PFPB_IC_ENT_TAG  55:32
`define PFPB_IC_ENT_W    56
`define PFPB_CS_AW       12
`define PFPB_CS_DW       48
`define PFPB_RF_AW       4
`define PFPB_PFB_DEPTH   2'h2
`define PFPB_PFB_EMPTY   2'h0
`define PFPB_PFB_ONE     2'h1
`endif

// ===== rtl/pfpb_pkg.sv
// Types shared by the pipeline core
package pfpb_pkg;
  typedef enum logic {
    pfpb_f_run  = 1'b0,
    pfpb_f_miss = 1'b1
  } pfpb_fstate_e;

  typedef struct packed {
    logic [31:0] instr;
    logic        pred;
    logic [31:0] alt;
  } pfpb_pfb_s;
endpackage

// ===== rtl/pfpb_mem.sv
// Small memory with registered, write-through read port
`timescale 1ns/1ns
module pfpb_mem #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] next_rdata;

  always_comb begin
    next_rdata = (we && (waddr == raddr)) ? wdata : mem[raddr];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule // pfpb_mem

// ===== rtl/pfpb_core.sv
// Five-stage pipeline core with prefetch, static prediction and bypass
`timescale 1ns/1ns
`include "pfpb_regs.svh"
module pfpb_core (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        cs_we,
  input  wire logic [11:0] cs_waddr,
  input  wire logic [47:0] cs_wdata,
  output logic             wb_valid,
  output logic [3:0]       wb_reg,
  output logic [31:0]      wb_data,
  output logic             mispredict
);
  pfpb_pkg::pfpb_fstate_e fstate, next_fstate;
  pfpb_pkg::pfpb_pfb_s    pfb0, pfb1, next_pfb0, next_pfb1, push_ent, of_ent, next_of_ent;
  logic [31:0] fpc, next_fpc, redirect_pc, next_redirect_pc, next_mem_addr, fword, ftgt;
  logic [63:0] ic_valid, next_ic_valid;
  logic [55:0] ic_rdata;
  logic [47:0] cs_rdata, ex_cw, next_ex_cw;
  logic [31:0] rfa_rdata, rfb_rdata, ex_a, ex_b, next_ex_a, next_ex_b;
  logic [31:0] alu_out, shift_out, ex_alt, next_ex_alt, next_wb_data;
  logic [3:0]  of_rx, of_ry, ex_rx, next_ex_rx, next_wb_reg;
  logic [1:0]  pfb_cnt, next_pfb_cnt, cnt;
  logic        next_mem_req, next_mispredict, ic_we, ic_hit, is_ubr, is_cbr, push;
  logic        pfb_pop, pfb_room, of_valid, next_of_valid, ex_valid, next_ex_valid;
  logic        ex_cbr, next_ex_cbr, ex_pred, next_ex_pred, ex_wr_now, taken, ex_mispredict;
  logic        next_wb_valid;

  function automatic logic [31:0] alu(input logic [2:0] op, input logic [31:0] a,
                                      input logic [31:0] b);
    case (op)
      `PFPB_ALU_ADD: alu = a + b;
      `PFPB_ALU_SUB: alu = a - b;
      `PFPB_ALU_AND: alu = a & b;
      `PFPB_ALU_OR:  alu = a | b;
      `PFPB_ALU_XOR: alu = a ^ b;
      default:       alu = b;
    endcase
  endfunction

  function automatic logic [31:0] barrel(input logic [31:0] v, input logic [1:0] m,
                                         input logic [4:0] n);
    logic [63:0] d;
    d = {v, v} >> n;
    case (m)
      `PFPB_SH_LEFT:  barrel = v << n;
      `PFPB_SH_RIGHT: barrel = v >> n;
      `PFPB_SH_ROT:   barrel = d[31:0];
      default:        barrel = v;
    endcase
  endfunction

  function automatic logic [31:0] pick(input logic [3:0] r, input logic [31:0] rf,
                                       input logic ex_w, input logic [3:0] ex_r,
                                       input logic [31:0] ex_d, input logic sr_w,
                                       input logic [3:0] sr_r, input logic [31:0] sr_d);
    if (ex_w && (ex_r == r)) begin
      pick = ex_d;
    end else if (sr_w && (sr_r == r)) begin
      pick = sr_d;
    end else begin
      pick = rf;
    end
  endfunction

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  pfpb_mem #(.AW(`PFPB_IC_AW), .DW(`PFPB_IC_ENT_W)) u_icache (
    .ref_clk (ref_clk), .arst_n (arst_n), .we (ic_we),
    .waddr (mem_addr[`PFPB_IC_IDX]), .wdata ({mem_addr[`PFPB_IC_TAG], mem_rdata}),
    .raddr (next_fpc[`PFPB_IC_IDX]), .rdata (ic_rdata));
  pfpb_mem #(.AW(`PFPB_CS_AW), .DW(`PFPB_CS_DW)) u_cstore (
    .ref_clk (ref_clk), .arst_n (arst_n), .we (cs_we), .waddr (cs_waddr),
    .wdata (cs_wdata), .raddr (12'(pfb0.instr[`PFPB_I_OP])), .rdata (cs_rdata));
  pfpb_mem #(.AW(`PFPB_RF_AW), .DW(32)) u_rf_first (
    .ref_clk (ref_clk), .arst_n (arst_n), .we (wb_valid), .waddr (wb_reg),
    .wdata (wb_data), .raddr (pfb0.instr[`PFPB_I_RX]), .rdata (rfa_rdata));
  pfpb_mem #(.AW(`PFPB_RF_AW), .DW(32)) u_rf_second (
    .ref_clk (ref_clk), .arst_n (arst_n), .we (wb_valid), .waddr (wb_reg),
    .wdata (wb_data), .raddr (pfb0.instr[`PFPB_I_RY]), .rdata (rfb_rdata));

  // ----------------------------------------------------------------
  // Fetch and prediction
  // ----------------------------------------------------------------
  always_comb begin
    fword = ic_rdata[31:0];
    ftgt = fpc + {{17{fword[`PFPB_I_DISP_MSB]}}, fword[`PFPB_I_DISP]};
    is_ubr = fword[`PFPB_I_OP] == `PFPB_OP_UBR;
    is_cbr = fword[`PFPB_I_OP] == `PFPB_OP_CBR;
    ic_hit = ic_valid[fpc[`PFPB_IC_IDX]] && (ic_rdata[`PFPB_IC_ENT_TAG] == fpc[`PFPB_IC_TAG]);
    next_fstate = fstate;
    next_fpc = fpc;
    next_mem_req = mem_req;
    next_mem_addr = mem_addr;
    next_redirect_pc = ex_mispredict ? ex_alt : redirect_pc;
    next_mispredict = ex_mispredict;
    next_ic_valid = ic_valid;
    ic_we = 1'b0;
    push = 1'b0;
    push_ent = '{instr: fword, pred: 1'b0, alt: ftgt};
    case (fstate)
      pfpb_pkg::pfpb_f_run: begin
        if (!mispredict && !ex_mispredict) begin
          if (!ic_hit) begin
            next_fstate = pfpb_pkg::pfpb_f_miss;
            next_mem_req = 1'b1;
            next_mem_addr = fpc;
          end else if (pfb_room) begin
            if (is_ubr) begin
              next_fpc = ftgt;
            end else begin
              push = 1'b1;
              if (is_cbr && fword[`PFPB_I_PRED]) begin
                push_ent.pred = 1'b1;
                push_ent.alt = fpc + `PFPB_PC_STEP;
                next_fpc = ftgt;
              end else begin
                next_fpc = fpc + `PFPB_PC_STEP;
              end
            end
          end
        end
      end
      pfpb_pkg::pfpb_f_miss: begin
        if (mem_ack) begin
          ic_we = 1'b1;
          next_ic_valid[mem_addr[`PFPB_IC_IDX]] = 1'b1;
          next_mem_req = 1'b0;
          next_fstate = pfpb_pkg::pfpb_f_run;
        end
      end
      default: next_fstate = pfpb_pkg::pfpb_f_run;
    endcase
    if (mispredict) begin
      next_fpc = redirect_pc;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fstate <= pfpb_pkg::pfpb_f_run;
      fpc <= `PFPB_RESET_PC;
      redirect_pc <= `PFPB_RESET_PC;
      mem_req <= 1'b0;
      mem_addr <= `PFPB_RESET_PC;
      mispredict <= 1'b0;
      ic_valid <= 64'h0;
    end else begin
      fstate <= next_fstate;
      fpc <= next_fpc;
      redirect_pc <= next_redirect_pc;
      mem_req <= next_mem_req;
      mem_addr <= next_mem_addr;
      mispredict <= next_mispredict;
      ic_valid <= next_ic_valid;
    end
  end

  // ----------------------------------------------------------------
  // Prefetch buffer and instruction fetch stage
  // ----------------------------------------------------------------
  always_comb begin
    cnt = pfb_cnt;
    pfb_pop = pfb_cnt != `PFPB_PFB_EMPTY;
    pfb_room = (pfb_cnt != `PFPB_PFB_DEPTH) || pfb_pop;
    next_pfb0 = pfb0;
    next_pfb1 = pfb1;
    if (pfb_pop) begin
      next_pfb0 = pfb1;
      cnt = cnt - `PFPB_PFB_ONE;
    end
    if (push) begin
      if (cnt == `PFPB_PFB_EMPTY) begin
        next_pfb0 = push_ent;
      end else begin
        next_pfb1 = push_ent;
      end
      cnt = cnt + `PFPB_PFB_ONE;
    end
    next_pfb_cnt = ex_mispredict ? `PFPB_PFB_EMPTY : cnt;
    next_of_valid = pfb_pop && !ex_mispredict;
    next_of_ent = pfb0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pfb_cnt <= `PFPB_PFB_EMPTY;
      pfb0 <= '0;
      pfb1 <= '0;
      of_valid <= 1'b0;
      of_ent <= '0;
    end else begin
      pfb_cnt <= next_pfb_cnt;
      pfb0 <= next_pfb0;
      pfb1 <= next_pfb1;
      of_valid <= next_of_valid;
      of_ent <= next_of_ent;
    end
  end

  // ----------------------------------------------------------------
  // Operand fetch, execute and store result
  // ----------------------------------------------------------------
  always_comb begin
    of_rx = of_ent.instr[`PFPB_I_RX];
    of_ry = of_ent.instr[`PFPB_I_RY];
    ex_wr_now = ex_valid && ex_cw[`PFPB_CW_WR] && !ex_cbr;
    alu_out = alu(ex_cw[`PFPB_CW_ALU], ex_a, ex_b);
    shift_out = barrel(alu_out, ex_cw[`PFPB_CW_SHM], ex_cw[`PFPB_CW_SHA]);
    case (ex_cw[`PFPB_CW_CND])
      `PFPB_CND_EQ: taken = ex_a == ex_b;
      `PFPB_CND_NE: taken = ex_a != ex_b;
      `PFPB_CND_LT: taken = $signed(ex_a) < $signed(ex_b);
      default:      taken = $signed(ex_a) >= $signed(ex_b);
    endcase
    ex_mispredict = ex_valid && ex_cbr && (taken != ex_pred);
    next_ex_valid = of_valid && !ex_mispredict;
    next_ex_cw = cs_rdata;
    next_ex_rx = of_rx;
    next_ex_cbr = of_ent.instr[`PFPB_I_OP] == `PFPB_OP_CBR;
    next_ex_pred = of_ent.pred;
    next_ex_alt = of_ent.alt;
    next_ex_a = pick(of_rx, rfa_rdata, ex_wr_now, ex_rx, shift_out,
                     wb_valid, wb_reg, wb_data);
    next_ex_b = cs_rdata[`PFPB_CW_IMM] ? 32'(of_ry) :
                pick(of_ry, rfb_rdata, ex_wr_now, ex_rx, shift_out,
                     wb_valid, wb_reg, wb_data);
    next_wb_valid = ex_wr_now;
    next_wb_reg = ex_rx;
    next_wb_data = shift_out;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ex_valid <= 1'b0;
      ex_cw <= '0;
      ex_rx <= '0;
      ex_cbr <= 1'b0;
      ex_pred <= 1'b0;
      ex_alt <= '0;
      ex_a <= '0;
      ex_b <= '0;
      wb_valid <= 1'b0;
      wb_reg <= '0;
      wb_data <= '0;
    end else begin
      ex_valid <= next_ex_valid;
      ex_cw <= next_ex_cw;
      ex_rx <= next_ex_rx;
      ex_cbr <= next_ex_cbr;
      ex_pred <= next_ex_pred;
      ex_alt <= next_ex_alt;
      ex_a <= next_ex_a;
      ex_b <= next_ex_b;
      wb_valid <= next_wb_valid;
      wb_reg <= next_wb_reg;
      wb_data <= next_wb_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_stage_flow: assert property (@(posedge ref_clk) disable iff (!arst_n)
    of_valid && !ex_mispredict |=> ex_valid) else $error("operand stage did not advance");
  a_result_reg: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ex_wr_now |=> wb_valid && wb_data == $past(shift_out) && wb_reg == $past(ex_rx))
    else $error("result register not captured");
  a_pred_path: assert property (@(posedge ref_clk) disable iff (!arst_n)
    push && is_cbr && !fword[`PFPB_I_PRED] |=> fpc == $past(fpc) + `PFPB_PC_STEP)
    else $error("unpredicted branch left sequential path");
  a_pred_target: assert property (@(posedge ref_clk) disable iff (!arst_n)
    push && is_cbr && fword[`PFPB_I_PRED] |=> fpc == $past(ftgt) && pfb0.pred)
    else $error("predicted branch did not redirect");
  a_restart_pc: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ex_mispredict |-> ##2 fpc == $past(ex_alt, 2)) else $error("wrong restart address");
  a_flush_gap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ex_mispredict |=> !ex_valid [*4]) else $error("mispredict gap not four cycles");
  a_ubr_fold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fstate == pfpb_pkg::pfpb_f_run && !mispredict && !ex_mispredict && ic_hit && is_ubr
    |=> fpc == $past(ftgt) && pfb_cnt == `PFPB_PFB_EMPTY) else $error("branch not folded");
  a_rotate_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ex_cw[`PFPB_CW_SHM] == `PFPB_SH_ROT |-> shift_out == ((alu_out >> ex_cw[`PFPB_CW_SHA])
    | (alu_out << (6'h20 - {1'b0, ex_cw[`PFPB_CW_SHA]})))) else $error("rotate wrong");
  a_bypass_ex: assert property (@(posedge ref_clk) disable iff (!arst_n)
    of_valid && ex_wr_now && ex_rx == of_rx |=> ex_a == $past(shift_out))
    else $error("first operand not forwarded");
  a_other_file: assert property (@(posedge ref_clk) disable iff (!arst_n)
    of_valid && !cs_rdata[`PFPB_CW_IMM] && !(ex_wr_now && ex_rx == of_ry)
    && !(wb_valid && wb_reg == of_ry) |=> ex_b == $past(rfb_rdata))
    else $error("second operand not from its file");
  a_squash_nowr: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ex_mispredict |=> !wb_valid [*5]) else $error("squashed instruction wrote");
endmodule // pfpb_core

// ===== testbench/pfpb_mem_model.sv
// Memory controller model answering instruction fetch reads
`timescale 1ns/1ns
module pfpb_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] prog [0:63];
  logic [1:0]  wait_cnt;

  // ----------------------------------------
  // Read answer, prompt or slow
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h5a5a_a5a5;
      wait_cnt  <= 2'h0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !hold && wait_cnt == 2'h0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= prog[mem_addr[7:2]];
      wait_cnt  <= slow ? 2'($urandom_range(3)) : 2'h0;
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_req && !hold) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule // pfpb_mem_model

// ===== testbench/tb_top.sv
// Self-checking bench for the pipeline core
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk, arst_n, cs_we, hold, slow, mem_req, mem_ack, wb_valid, mispredict;
  logic [11:0] cs_waddr;
  logic [47:0] cs_wdata;
  logic [31:0] mem_rdata, mem_addr, wb_data;
  logic [3:0]  wb_reg;
  logic [47:0] cw [0:255];
  logic [31:0] rf [0:15];
  logic [39:0] exp_q [$];
  logic [39:0] e;
  int          n_fail, checked, last_wb, n_mp, exp_mp;
  int          cyc = 0;

  pfpb_core pfpb_core_i (.ref_clk(ref_clk), .arst_n(arst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cs_we(cs_we),
    .cs_waddr(cs_waddr), .cs_wdata(cs_wdata), .wb_valid(wb_valid), .wb_reg(wb_reg),
    .wb_data(wb_data), .mispredict(mispredict));
  pfpb_mem_model pfpb_mem_model_i (.ref_clk(ref_clk), .arst_n(arst_n), .hold(hold),
    .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Reference instruction model
  // ----------------------------------------
  function automatic logic [31:0] ins(logic [7:0] op, int rx, int ry, int p, int d);
    return {op, 4'(rx), 4'(ry), 1'(p), 15'(d)};
  endfunction

  function automatic logic [31:0] alu(logic [31:0] a, logic [31:0] b, logic [2:0] f);
    case (f)
      3'h0: return a + b;
      3'h1: return a - b;
      3'h2: return a & b;
      3'h3: return a | b;
      3'h4: return a ^ b;
      default: return b;
    endcase
  endfunction

  function automatic logic [31:0] shf(logic [31:0] v, logic [1:0] m, logic [4:0] n);
    case (m)
      2'h1: return v << n;
      2'h2: return v >> n;
      2'h3: return (v >> n) | (v << (6'h20 - {1'b0, n}));
      default: return v;
    endcase
  endfunction

  task automatic sim;
    logic [31:0] pc, a, b, r, w;
    logic [47:0] c;
    logic        vis [0:63];
    logic        ok, tk;
    int          nex;
    pc = 32'h0;
    ok = 1'b0;
    nex = 0;
    foreach (vis[k]) vis[k] = 1'b0;
    for (int s = 0; s < 300; s++) begin
      w = pfpb_mem_model_i.prog[pc[7:2]];
      if (w[31:24] == 8'hf0) begin
        if (w[14:0] == 15'h0) break;
        pc = pc + {{17{w[14]}}, w[14:0]};
        ok = 1'b0;
        continue;
      end
      c = cw[w[31:24]];
      a = rf[w[23:20]];
      b = c[11] ? {28'h0, w[19:16]} : rf[w[19:16]];
      ok = ok & vis[pc[7:2]];
      vis[pc[7:2]] = 1'b1;
      nex++;
      if (w[31:24] == 8'he0) begin
        tk = (c[13:12] == 2'h0) ? a == b : (c[13:12] == 2'h1) ? a != b :
             ($signed(a) < $signed(b)) ^ c[12];
        if (tk != w[15]) begin
          exp_mp++;
          nex += 4;
        end
        pc = tk ? pc + {{17{w[14]}}, w[14:0]} : pc + 32'h4;
      end else begin
        r = shf(alu(a, b, c[2:0]), c[4:3], c[9:5]);
        if (c[10]) begin
          rf[w[23:20]] = r;
          exp_q.push_back({ok ? 4'(nex) : 4'h0, w[23:20], r});
          nex = 0;
          ok = 1'b1;
        end
        pc = pc + 32'h4;
      end
    end
  endtask

  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  task automatic cs_wr(input logic [7:0] op, input logic [47:0] d);
    cw[op] = d;
    cs_we <= 1'b1;
    cs_waddr <= {4'h0, op};
    cs_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic build(input int rnd);
    logic [3:0]  prv, rx;
    logic [47:0] d;
    prv = 4'h0;
    for (int k = 0; k < 64; k++) pfpb_mem_model_i.prog[k] = ins(8'hf0, 0, 0, 0, 0);
    for (int k = 0; k < 16; k++) pfpb_mem_model_i.prog[k] = ins(8'h01, 4'(k), 4'($urandom), 0, 0);
    pfpb_mem_model_i.prog[16] = ins(8'h01, 15, 3, 0, 0);
    pfpb_mem_model_i.prog[17] = ins(8'hf0, 0, 0, 0, 15'h8);
    pfpb_mem_model_i.prog[18] = ins(8'h01, 14, 5, 0, 0);
    for (int k = 19; k < 23; k++) begin
      rx = 4'($urandom_range(14));
      pfpb_mem_model_i.prog[k] = ins(8'h10 + 8'($urandom_range(15)), rx, prv, 0, 0);
      prv = rx;
    end
    pfpb_mem_model_i.prog[23] = ins(8'h02, 15, 1, 0, 0);
    pfpb_mem_model_i.prog[24] = ins(8'he0, 15, 0, 1, 15'h7fec);
    pfpb_mem_model_i.prog[25] = ins(8'h01, 15, 3, 0, 0);
    pfpb_mem_model_i.prog[26] = ins(8'h02, 15, 1, 0, 0);
    pfpb_mem_model_i.prog[27] = ins(8'he0, 15, 0, 0, 15'h7ffc);
    cs_wr(8'h01, 48'h0c07);
    cs_wr(8'h02, 48'h0c01);
    cs_wr(8'he0, {34'h0, 2'(rnd ^ 1), 12'h800});
    for (int k = 0; k < 16; k++) begin
      d = {36'h0, 1'(k >> 3), 1'b1, 5'($urandom), 2'($urandom), 3'(k)};
      if (k == 5) d[9:3] = 7'h7f;
      cs_wr(8'h10 + 8'(k), d);
    end
    cs_we <= 1'b0;
  endtask

  // ----------------------------------------
  // Clock, watchdog, monitor
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report;
  end

  always @(negedge ref_clk) begin
    if (arst_n && mispredict === 1'b1) n_mp++;
    if (arst_n && wb_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        chk({28'h0, wb_reg}, {28'h0, e[35:32]});
        chk(wb_data, e[31:0]);
        if (e[39:36] != 4'h0) chk(32'(cyc - last_wb), {28'h0, e[39:36]});
      end
      last_wb = cyc;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    cs_we = 1'b0;
    cs_waddr = 12'h0;
    cs_wdata = 48'h0;
    hold = 1'b1;
    slow = 1'b0;
    n_fail = 0;
    checked = 0;
    last_wb = 0;
    void'($urandom(71));
    for (int rnd = 0; rnd < 4; rnd++) begin
      n_mp = 0;
      exp_mp = 0;
      arst_n <= 1'b0;
      hold <= 1'b1;
      slow <= (rnd == 1);
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      build(rnd);
      chk(mem_addr, 32'h0);
      chk({31'h0, mem_req}, 32'h1);
      sim;
      hold <= 1'b0;
      for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge ref_clk);
      repeat (30) @(posedge ref_clk);
      chk(32'(exp_q.size()), 32'h0);
      chk(32'(n_mp), 32'(exp_mp));
      $display("test %0d done", rnd);
    end
    final_report;
  end
endmodule // tb_top
